/* File: inc/see_pkg.sv */
// Constants and types shared by the serial EEPROM controller
package see_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFS_CMD = 8'hB0;
  localparam logic [7:0] OFS_DATA = 8'hB4;
  localparam logic [7:0] OFS_ISTS = 8'hB8;
  localparam logic [7:0] OFS_IMSK = 8'hBC;
  // Command and status register fields
  localparam int CMD_BUSY_BIT = 31;
  localparam int CMD_OP_LSB = 28;
  localparam int CMD_TMO_BIT = 9;
  localparam int CMD_LOADED_BIT = 8;
  // Reset values
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [1:0] IMSK_RST = 2'h0;
  // Interrupt status bit positions
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_TMO_BIT = 1;
  // Software command codes
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_EW_DISABLE = 3'h1,
    OP_EW_ENABLE = 3'h2,
    OP_WRITE = 3'h3,
    OP_WRITE_ALL = 3'h4,
    OP_ERASE = 3'h5,
    OP_BULK_ERASE = 3'h6,
    OP_RELOAD = 3'h7
  } see_op_t;
  // Serial opcodes and extended sub-codes
  localparam logic [1:0] OPC_READ = 2'h2;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_ERASE = 2'h3;
  localparam logic [1:0] OPC_EXT = 2'h0;
  localparam logic [1:0] SUB_EW_ENABLE = 2'h3;
  localparam logic [1:0] SUB_EW_DISABLE = 2'h0;
  localparam logic [1:0] SUB_WRITE_ALL = 2'h1;
  localparam logic [1:0] SUB_BULK_ERASE = 2'h2;
  // Station address reload
  localparam logic [7:0] SIG_BYTE = 8'hA5;
  localparam int MAC_BYTES = 6;
  // Timing
  localparam int CLK_HZ = 40000000;
  localparam int CLK_NS = 25;
  localparam int TIMEOUT_MS = 30;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int SCLK_HALF_NS = 1000;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
endpackage

/* File: verilog/see_shifter.sv */
// Serial frame shifter with its own serial clock divider
`timescale 1ns/10ps
`default_nettype none
module see_shifter #(
  parameter int FRAME_W = 19,
  parameter int HALF_CYC = 40
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic start_i,
  input wire logic [FRAME_W-1:0] tx_i,
  input wire logic [$clog2(FRAME_W+1)-1:0] nbits_i,
  input wire logic [$clog2(FRAME_W+1)-1:0] txbits_i,
  input wire logic din_i,
  output logic sclk_o,
  output logic dout_o,
  output logic doe_o,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rx_o
);
  localparam int CW = $clog2(FRAME_W+1);
  localparam int DW = $clog2(HALF_CYC+1);
  logic [DW-1:0] div_q; // Half period counter
  logic [CW-1:0] left_q; // Bits still to clock
  logic [CW-1:0] txl_q; // Bits still driven by us
  logic [FRAME_W-1:0] sh_q; // Outgoing shift register
  logic tick; // Half period enable

  assign tick = (div_q == DW'(HALF_CYC - 1));
  assign dout_o = sh_q[FRAME_W-1];

  // Divider runs only while a frame is active
  always_ff @(posedge clock_i)
  begin
    if (srst_i || !busy_o)
      div_q <= '0;
    else if (tick)
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end

  // Frame sequencer: data changes on falling, sampled on rising
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      busy_o <= 1'b0;
      sclk_o <= 1'b0;
      done_o <= 1'b0;
      doe_o <= 1'b0;
      left_q <= '0;
      txl_q <= '0;
      sh_q <= '0;
      rx_o <= 8'h00;
    end
    else
    begin
      done_o <= 1'b0;
      if (!busy_o)
      begin
        // Load a new frame
        if (start_i)
        begin
          busy_o <= 1'b1;
          doe_o <= 1'b1;
          sh_q <= tx_i;
          left_q <= nbits_i;
          txl_q <= txbits_i;
        end
      end
      else if (tick)
      begin
        sclk_o <= ~sclk_o;
        if (!sclk_o)
        begin
          // Rising edge: capture a read bit once we stop driving
          if (txl_q == '0)
            rx_o <= {rx_o[6:0], din_i};
        end
        else
        begin
          // Falling edge: move to the next bit
          sh_q <= {sh_q[FRAME_W-2:0], 1'b0};
          left_q <= left_q - 1'b1;
          doe_o <= (txl_q > CW'(1));
          if (txl_q != '0)
            txl_q <= txl_q - 1'b1;
          if (left_q == CW'(1))
          begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: verilog/see_ctrl.sv */
// Serial EEPROM controller with AHB-Lite register slave
// Functional notes
// RULE1: EEPROM accepts programming after enable, until disable
// RULE2: EEPROM powers up with programming disabled
// RULE3: Write stores data byte at addressed location
// RULE4: Write-all stores data byte everywhere
// RULE5: Erase clears location; bulk erase clears all
// RULE6: Reload rereads station address if signature matches
// RULE7: No response within timeout abandons operation
// RULE8: Timeout sets timeout status bit
// RULE9: Data line high: no timeout, busy clears
// RULE10: Only programming commands wait and time out
// RULE11: Loaded bit flags valid EEPROM and address
// RULE12: Loaded set after boot or reload success
// RULE13: Eight-bit address field, resets to zero
// RULE14: Data byte low, upper bits read zero
// RULE15: Commands use and return the data byte
// RULE16: Busy on command, extra commands ignored
// RULE17: Drive clock, select, data in protocol order
`timescale 1ns/10ps
`default_nettype none
module see_ctrl #(
  parameter int ADDR_W = 8,
  parameter int TMO_CYC = see_pkg::TIMEOUT_CYC
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic ee_sclk_o,
  output logic ee_cs_o,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe_o,
  output logic [47:0] station_addr_o,
  output logic irq_o
);
  localparam int FRAME_W = 3 + ADDR_W + 8;
  localparam int CW = $clog2(FRAME_W+1);
  localparam int TW = $clog2(TMO_CYC+1);

  // Sequencer states, Gray along the path
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_GAP = 2'b11,
    ST_WAIT = 2'b10
  } see_state_t;

  see_state_t state_q; // Sequencer state
  see_pkg::see_op_t op_q; // Command in progress
  logic [ADDR_W-1:0] addr_q; // Location field
  logic [7:0] data_q; // Data byte
  logic busy_q; // Command running
  logic tmo_q; // Last command timed out
  logic loaded_q; // Station address valid
  logic boot_q; // Power-up reload pending
  logic [2:0] rl_idx_q; // Reload byte index
  logic [47:0] stn_q; // Station address
  logic [TW-1:0] cnt_q; // Gap and timeout counter
  logic [1:0] ists_q; // Sticky event bits
  logic [1:0] imsk_q; // Event mask
  logic irq_q; // Interrupt line
  logic din_m_q; // Data pin, first stage
  logic din_s_q; // Data pin, synchronised
  logic ap_wr_q; // Write data phase pending
  logic ap_rd_q; // Read data phase pending
  logic [7:0] ap_addr_q; // Latched address
  logic ee_cs_q; // Chip select
  logic sh_start_q; // Frame launch strobe
  logic [FRAME_W-1:0] sh_tx_q; // Frame bits
  logic [CW-1:0] sh_nb_q; // Frame length
  logic [CW-1:0] sh_txb_q; // Driven bits
  logic sh_busy; // Shifter active
  logic sh_done; // Shifter finished
  logic [7:0] sh_rx; // Shifted-in byte

  // Programming commands are the ones that wait for ready
  function automatic logic is_prog(input see_pkg::see_op_t op);
    is_prog = (op == see_pkg::OP_WRITE) || (op == see_pkg::OP_WRITE_ALL) ||
              (op == see_pkg::OP_ERASE) || (op == see_pkg::OP_BULK_ERASE);
  endfunction

  // Build start bit, opcode, address and data for a command
  function automatic logic [FRAME_W-1:0] frame_bits(input see_pkg::see_op_t op,
    input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [ADDR_W-3:0] pad;
    pad = '0;
    unique case (op)
      see_pkg::OP_READ, see_pkg::OP_RELOAD:
        frame_bits = {1'b1, see_pkg::OPC_READ, a, 8'h00};
      see_pkg::OP_WRITE:
        frame_bits = {1'b1, see_pkg::OPC_WRITE, a, d};
      see_pkg::OP_ERASE:
        frame_bits = {1'b1, see_pkg::OPC_ERASE, a, 8'h00};
      see_pkg::OP_EW_ENABLE:
        frame_bits = {1'b1, see_pkg::OPC_EXT, see_pkg::SUB_EW_ENABLE, pad, 8'h00};
      see_pkg::OP_EW_DISABLE:
        frame_bits = {1'b1, see_pkg::OPC_EXT, see_pkg::SUB_EW_DISABLE, pad, 8'h00};
      see_pkg::OP_WRITE_ALL:
        frame_bits = {1'b1, see_pkg::OPC_EXT, see_pkg::SUB_WRITE_ALL, pad, d};
      see_pkg::OP_BULK_ERASE:
        frame_bits = {1'b1, see_pkg::OPC_EXT, see_pkg::SUB_BULK_ERASE, pad, 8'h00};
    endcase
  endfunction

  // Bus decode strobes
  logic ap_take;
  logic wr_cmd;
  logic wr_data;
  logic wr_ists;
  logic wr_imsk;
  assign ap_take = hsel_i & hready_i & htrans_i[1];
  assign wr_cmd = ap_wr_q && (ap_addr_q == see_pkg::OFS_CMD);
  assign wr_data = ap_wr_q && (ap_addr_q == see_pkg::OFS_DATA);
  assign wr_ists = ap_wr_q && (ap_addr_q == see_pkg::OFS_ISTS);
  assign wr_imsk = ap_wr_q && (ap_addr_q == see_pkg::OFS_IMSK);

  // Sequencer conditions
  see_pkg::see_op_t new_op;
  logic cmd_go;
  logic boot_go;
  logic gap_end;
  logic wait_ok;
  logic wait_tmo;
  logic rl_fail;
  logic rl_last;
  logic rl_more;
  logic finish;
  assign new_op = see_pkg::see_op_t'(hwdata_i[see_pkg::CMD_OP_LSB +: 3]);
  assign cmd_go = wr_cmd && hwdata_i[see_pkg::CMD_BUSY_BIT] && !busy_q && !boot_q; // RULE16
  assign boot_go = boot_q && !busy_q; // RULE12
  assign gap_end = (state_q == ST_GAP) && (cnt_q == TW'(see_pkg::SCLK_HALF_CYC - 1));
  // Ignore the two synchroniser cycles after reselect: they still show the gap level
  assign wait_ok = (state_q == ST_WAIT) && din_s_q && (cnt_q > TW'(1)); // RULE9
  assign wait_tmo = (state_q == ST_WAIT) && !din_s_q && (cnt_q == TW'(TMO_CYC - 1)); // RULE7
  assign rl_fail = gap_end && (op_q == see_pkg::OP_RELOAD) && (rl_idx_q == 3'd0) &&
                   (sh_rx != see_pkg::SIG_BYTE); // RULE6
  assign rl_last = gap_end && (op_q == see_pkg::OP_RELOAD) &&
                   (rl_idx_q == 3'(see_pkg::MAC_BYTES));
  assign rl_more = gap_end && (op_q == see_pkg::OP_RELOAD) && !rl_fail && !rl_last;
  assign finish = wait_ok || wait_tmo || rl_fail || rl_last ||
                  (gap_end && !is_prog(op_q) && (op_q != see_pkg::OP_RELOAD)); // RULE10

  // Two-flop synchroniser for the data pin
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      din_m_q <= 1'b0;
      din_s_q <= 1'b0;
    end
    else
    begin
      din_m_q <= serial_data_line_i;
      din_s_q <= din_m_q;
    end
  end

  // Bus address phase capture and read data
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      ap_wr_q <= 1'b0;
      ap_rd_q <= 1'b0;
      ap_addr_q <= 8'h00;
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      ap_wr_q <= ap_take && hwrite_i;
      ap_rd_q <= ap_take && !hwrite_i;
      if (ap_take)
        ap_addr_q <= haddr_i[7:0];
      if (ap_take && !hwrite_i)
      begin
        // Unmapped offsets read as zero
        unique case (haddr_i[7:0])
          see_pkg::OFS_CMD:
            hrdata_o <= {busy_q, op_q, 18'h0_0000, tmo_q, loaded_q, 8'(addr_q)}; // RULE11
          see_pkg::OFS_DATA:
            hrdata_o <= {24'h00_0000, data_q}; // RULE14
          see_pkg::OFS_ISTS:
            hrdata_o <= {30'h0000_0000, ists_q};
          see_pkg::OFS_IMSK:
            hrdata_o <= {30'h0000_0000, imsk_q};
          default:
            hrdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Command register fields and busy flag
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      addr_q <= ADDR_W'(see_pkg::ADDR_RST); // RULE13
      op_q <= see_pkg::OP_READ;
      busy_q <= 1'b0;
      tmo_q <= 1'b0;
      boot_q <= 1'b1;
    end
    else
    begin
      if (boot_go)
      begin
        op_q <= see_pkg::OP_RELOAD;
        busy_q <= 1'b1;
        boot_q <= 1'b0;
      end
      else if (cmd_go)
      begin
        op_q <= new_op;
        addr_q <= hwdata_i[ADDR_W-1:0];
        busy_q <= 1'b1; // RULE16
        tmo_q <= 1'b0;
      end
      else if (wr_cmd && !busy_q)
      begin
        // Idle write without start bit updates the fields only
        op_q <= new_op;
        addr_q <= hwdata_i[ADDR_W-1:0]; // RULE13
      end
      if (finish)
        busy_q <= 1'b0; // RULE16
      if (wait_tmo)
        tmo_q <= 1'b1; // RULE8
    end
  end

  // Data byte: software writes when idle, reads land here
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      data_q <= see_pkg::DATA_RST;
    else if (sh_done && (op_q == see_pkg::OP_READ))
      data_q <= sh_rx; // RULE15
    else if (wr_data && !busy_q)
      data_q <= hwdata_i[7:0]; // RULE14
  end

  // Sequencer, chip select and frame launch
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      ee_cs_q <= 1'b0;
      sh_start_q <= 1'b0;
      sh_tx_q <= '0;
      sh_nb_q <= '0;
      sh_txb_q <= '0;
      rl_idx_q <= 3'd0;
    end
    else
    begin
      sh_start_q <= 1'b0;
      cnt_q <= cnt_q + 1'b1;
      unique case (state_q)
        ST_IDLE:
        begin
          if (boot_go || cmd_go)
          begin
            // Select the part and hand the frame to the shifter
            state_q <= ST_SHIFT;
            ee_cs_q <= 1'b1; // RULE17
            sh_start_q <= 1'b1;
            rl_idx_q <= 3'd0;
            if (boot_go)
              sh_tx_q <= frame_bits(see_pkg::OP_RELOAD, '0, 8'h00);
            else
              sh_tx_q <= frame_bits(new_op, hwdata_i[ADDR_W-1:0], data_q); // RULE3 RULE4 RULE5
            if (!boot_go && (new_op == see_pkg::OP_WRITE || new_op == see_pkg::OP_WRITE_ALL))
              sh_txb_q <= CW'(FRAME_W);
            else
              sh_txb_q <= CW'(3 + ADDR_W);
            if (!boot_go && (new_op == see_pkg::OP_EW_ENABLE ||
                new_op == see_pkg::OP_EW_DISABLE || new_op == see_pkg::OP_ERASE ||
                new_op == see_pkg::OP_BULK_ERASE))
              sh_nb_q <= CW'(3 + ADDR_W);
            else
              sh_nb_q <= CW'(FRAME_W);
          end
        end
        ST_SHIFT:
        begin
          if (sh_done)
          begin
            // Deselect between frame and status check
            state_q <= ST_GAP;
            ee_cs_q <= 1'b0; // RULE17
            cnt_q <= '0;
          end
        end
        ST_GAP:
        begin
          if (gap_end && is_prog(op_q))
          begin
            // Reselect and poll the ready level
            state_q <= ST_WAIT;
            ee_cs_q <= 1'b1; // RULE10
            cnt_q <= '0;
          end
          else if (rl_more)
          begin
            // Next station address byte
            state_q <= ST_SHIFT;
            ee_cs_q <= 1'b1;
            sh_start_q <= 1'b1;
            rl_idx_q <= rl_idx_q + 3'd1;
            sh_tx_q <= frame_bits(see_pkg::OP_RELOAD, ADDR_W'(rl_idx_q + 3'd1), 8'h00); // RULE6
            sh_nb_q <= CW'(FRAME_W);
            sh_txb_q <= CW'(3 + ADDR_W);
          end
          else if (finish)
            state_q <= ST_IDLE;
        end
        ST_WAIT:
        begin
          if (finish)
          begin
            state_q <= ST_IDLE; // RULE7
            ee_cs_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // Station address capture and loaded flag
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      stn_q <= 48'h0000_0000_0000;
      loaded_q <= 1'b0;
    end
    else
    begin
      if (gap_end && (op_q == see_pkg::OP_RELOAD) && (rl_idx_q != 3'd0))
        stn_q <= {sh_rx, stn_q[47:8]}; // RULE6
      if (boot_go || (cmd_go && new_op == see_pkg::OP_RELOAD))
        loaded_q <= 1'b0;
      else if (rl_last)
        loaded_q <= 1'b1; // RULE12
    end
  end

  // Sticky events, write one to clear, set wins
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      ists_q <= 2'h0;
      imsk_q <= see_pkg::IMSK_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      ists_q[see_pkg::IRQ_DONE_BIT] <= finish ||
        (ists_q[see_pkg::IRQ_DONE_BIT] && !(wr_ists && hwdata_i[see_pkg::IRQ_DONE_BIT]));
      ists_q[see_pkg::IRQ_TMO_BIT] <= wait_tmo ||
        (ists_q[see_pkg::IRQ_TMO_BIT] && !(wr_ists && hwdata_i[see_pkg::IRQ_TMO_BIT]));
      if (wr_imsk)
        imsk_q <= hwdata_i[1:0];
      irq_q <= |(ists_q & imsk_q);
    end
  end

  // Frame shifter and serial clock divider
  see_shifter #(
    .FRAME_W(FRAME_W),
    .HALF_CYC(see_pkg::SCLK_HALF_CYC)
  ) u_shifter (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .start_i(sh_start_q),
    .tx_i(sh_tx_q),
    .nbits_i(sh_nb_q),
    .txbits_i(sh_txb_q),
    .din_i(din_s_q),
    .sclk_o(ee_sclk_o),
    .dout_o(serial_data_line_o),
    .doe_o(serial_data_line_oe_o),
    .busy_o(sh_busy),
    .done_o(sh_done),
    .rx_o(sh_rx)
  );

  assign ee_cs_o = ee_cs_q;
  assign station_addr_o = stn_q;
  assign irq_o = irq_q;

  // Checks
  AST_BUSY_SET: assert property (@(posedge clock_i) disable iff (srst_i) // RULE16
    cmd_go |=> busy_q && state_q == ST_SHIFT) else $error("command did not raise busy");
  AST_CMD_HELD: assert property (@(posedge clock_i) disable iff (srst_i) // RULE16
    wr_cmd && busy_q |=> $stable(op_q) && $stable(addr_q)) else $error("command taken while busy");
  AST_TMO_FLAG: assert property (@(posedge clock_i) disable iff (srst_i) // RULE8
    wait_tmo |=> tmo_q && !busy_q && ists_q[see_pkg::IRQ_TMO_BIT]) else $error("timeout not flagged");
  AST_TMO_IDLE: assert property (@(posedge clock_i) disable iff (srst_i) // RULE7
    wait_tmo |=> state_q == ST_IDLE && !ee_cs_q) else $error("timeout did not abandon");
  AST_HIGH_OK: assert property (@(posedge clock_i) disable iff (srst_i) // RULE9
    state_q == ST_WAIT && din_s_q && cnt_q > TW'(1) |=> !tmo_q && !busy_q)
    else $error("ready line not honoured");
  AST_NO_WAIT: assert property (@(posedge clock_i) disable iff (srst_i) // RULE10
    gap_end && !is_prog(op_q) |=> state_q != ST_WAIT) else $error("non-programming wait");
  AST_SIG_GATE: assert property (@(posedge clock_i) disable iff (srst_i) // RULE6
    rl_fail |=> !loaded_q && !busy_q) else $error("bad signature accepted");
  AST_LOAD_SET: assert property (@(posedge clock_i) disable iff (srst_i) // RULE12
    rl_last |=> loaded_q ##1 loaded_q) else $error("loaded not set after reload");
  AST_DATA_HI: assert property (@(posedge clock_i) disable iff (srst_i) // RULE14
    ap_rd_q && ap_addr_q == see_pkg::OFS_DATA |-> hrdata_o[31:8] == 24'h00_0000)
    else $error("data upper bits not zero");
  AST_READ_BACK: assert property (@(posedge clock_i) disable iff (srst_i) // RULE15
    sh_done && op_q == see_pkg::OP_READ |=> data_q == $past(sh_rx)) else $error("read data lost");
  AST_CS_FRAME: assert property (@(posedge clock_i) disable iff (srst_i) // RULE17
    sh_busy |-> ee_cs_q) else $error("clocking without select");
  AST_IRQ: assert property (@(posedge clock_i) disable iff (srst_i)
    (ists_q & imsk_q) != 2'h0 |=> irq_o) else $error("interrupt not raised");
endmodule
`default_nettype wire

/* File: test/see_eeprom_model.sv */
// Behavioural serial EEPROM partner
`timescale 1ns/10ps
`default_nettype none
module see_eeprom_model #(
  parameter logic [7:0] ERASED = 8'hFF
) (
  input wire logic sclk_i,
  input wire logic cs_i,
  input wire logic din_i,
  input wire logic present_i,
  input wire logic [31:0] busy_ns_i,
  output wire logic do_o,
  output wire logic oe_o
);
  logic [7:0] mem [256]; // Storage cells
  logic [10:0] hdr = 11'h000; // Start bit, opcode, address
  logic [7:0] wd = 8'h00; // Incoming data byte
  logic [7:0] rd = 8'h00; // Outgoing data byte
  logic rbit = 1'b0; // Bit on the line while reading
  logic rdo = 1'b0; // Read data phase
  logic stat = 1'b0; // Ready status phase
  logic pend = 1'b0; // Status phase follows this frame
  logic ready = 1'b1; // Internal programming finished
  logic ew_en = 1'b0; // Programming locked at power-up
  int n = 0; // Clock count within the frame
  // Drives only when fitted
  assign do_o = stat ? ready : rbit;
  assign oe_o = present_i & (stat | rdo);
  // Blank memory at power-up
  initial
    foreach (mem[i]) mem[i] = ERASED;
  // Stores if unlocked, then busy
  task automatic prog(input logic all, input logic [7:0] a, input logic [7:0] v);
    pend = 1'b1;
    if (ew_en)
    begin
      foreach (mem[i]) if (all || i == a) mem[i] = v;
      ready = 1'b0;
      ready <= #(busy_ns_i) 1'b1;
    end
  endtask
  // Select opens frame or status
  always @(posedge cs_i)
  begin
    n = 0;
    stat = pend;
    pend = 1'b0;
  end
  // Deselect releases line
  always @(negedge cs_i)
  begin
    stat = 1'b0;
    rdo = 1'b0;
  end
  // Shift in on rising clock
  always @(posedge sclk_i)
    if (cs_i && !stat)
    begin
      n = n + 1;
      if (n <= 11) hdr = {hdr[9:0], din_i};
      else wd = {wd[6:0], din_i};
      if (n == 11 && hdr[10])
      begin
        rdo = hdr[9:8] == 2'h2;
        rd = mem[hdr[7:0]];
        if (hdr[9:8] == 2'h3) prog(1'b0, hdr[7:0], ERASED);
        if (hdr[9:6] == 4'h2) prog(1'b1, hdr[7:0], ERASED);
        if (hdr[9:6] == 4'h3) ew_en = 1'b1;
        if (hdr[9:6] == 4'h0) ew_en = 1'b0;
      end
      if (n == 19 && hdr[10] && (hdr[9:8] == 2'h1 || hdr[9:6] == 4'h1))
        prog(hdr[9:8] == 2'h0, hdr[7:0], wd);
    end
  // Read bits on falling clock
  always @(negedge sclk_i)
    if (rdo && cs_i)
    begin
      rbit = rd[7];
      rd = {rd[6:0], 1'b0};
    end
endmodule
`default_nettype wire

/* File: test/serial_eeprom_controller_tb_top.sv */
// Bench for the serial EEPROM controller
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_controller_tb_top;
  localparam int TMO = 2000; // Short response timeout
  localparam int LIMIT = 99000; // Cycle ceiling of the run
  localparam logic [7:0] CMD = see_pkg::OFS_CMD, DAT = see_pkg::OFS_DATA; // Offsets
  localparam logic [7:0] STS = see_pkg::OFS_ISTS, MSK = see_pkg::OFS_IMSK;
  localparam logic [7:0] SIG = see_pkg::SIG_BYTE; // Signature
  localparam logic [7:0] ERASED = 8'hFF; // Blank cell value
  localparam logic [31:0] ALL = 32'hFFFF_FFFF; // Full compare mask
  typedef struct {string nm; logic [47:0] exp; logic [47:0] msk; logic [1:0] src;} see_note_t;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic pull = 1'b1; // Line pull level
  logic present = 1'b1; // Memory chip fitted
  logic [31:0] busy_ns = 32'h1388; // Chip programming time
  logic probe = 1'b0; // Oldest note due
  logic [47:0] st; // Expected station address
  logic [47:0] got; // Value under comparison
  see_note_t nt; // Note being compared
  see_note_t notes[$]; // Pending expectations
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  wire logic [31:0] hrdata_o;
  wire logic [47:0] station_addr_o;
  wire logic hreadyout_o, hresp_o, ee_sclk_o, ee_cs_o, sdl_o, sdl_oe, m_do, m_oe, irq_o;
  // Shared data line
  wire logic line = sdl_oe ? sdl_o : (m_oe ? m_do : pull);
  see_ctrl #(.TMO_CYC(TMO)) u_dut (.clock_i(clock_i), .srst_i(srst_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(3'h2), .hready_i(hreadyout_o), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .ee_sclk_o(ee_sclk_o), .ee_cs_o(ee_cs_o),
    .serial_data_line_i(line), .serial_data_line_o(sdl_o), .serial_data_line_oe_o(sdl_oe),
    .station_addr_o(station_addr_o), .irq_o(irq_o));
  see_eeprom_model #(.ERASED(ERASED)) u_mem (.sclk_i(ee_sclk_o), .cs_i(ee_cs_o),
    .din_i(line), .present_i(present), .busy_ns_i(busy_ns), .do_o(m_do), .oe_o(m_oe));
  // Clock at 40 MHz
  always #12.5 clock_i = ~clock_i;
  // Verdict
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Cuts a hang short
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fails++;
      wrap_up();
    end
  end
  // Checks the oldest note; bit 32 of a register note is the response
  always @(posedge clock_i)
    if (probe)
    begin
      nt = notes.pop_front();
      got = nt.src == 2'h0 ? {15'h0, hresp_o, hrdata_o} :
        nt.src == 2'h1 ? {47'h0, irq_o} : station_addr_o;
      samples_checked++;
      if ((got & nt.msk) !== nt.exp)
      begin
        fails++;
        $display("wrong value %s expected %h seen %h", nt.nm, nt.exp, got & nt.msk);
      end
    end
  // One AHB-Lite transfer; pr flags a checked read
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic pr,
    output logic [31:0] rd);
    @(posedge clock_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    haddr_i <= {24'h00_0000, a};
    @(posedge clock_i);
    while (hreadyout_o !== 1'b1) @(posedge clock_i);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    probe <= pr;
    @(posedge clock_i);
    while (hreadyout_o !== 1'b1) @(posedge clock_i);
    rd = hrdata_o;
    probe <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, 1'b0, x);
  endtask
  // Notes and reads a register
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] e,
    input logic [31:0] m);
    logic [31:0] x;
    notes.push_back('{nm, {16'h0, e}, {16'h1, m}, 2'h0});
    bus(1'b0, a, 32'h0, 1'b1, x);
  endtask
  // Notes a pin: 1 irq, 2 station
  task automatic look(input string nm, input logic [1:0] s, input logic [47:0] e);
    notes.push_back('{nm, e, 48'hFFFF_FFFF_FFFF, s});
    @(posedge clock_i);
    probe <= 1'b1;
    @(posedge clock_i);
    probe <= 1'b0;
  endtask
  // Polls until the busy bit drops
  task automatic idle();
    logic [31:0] x;
    x = ALL;
    while (x[see_pkg::CMD_BUSY_BIT] !== 1'b0) bus(1'b0, CMD, 32'h0, 1'b0, x);
  endtask
  task automatic run(input logic [2:0] op, input logic [7:0] a);
    wr(CMD, {1'b1, op, 20'h0, a});
    idle();
  endtask
  // Read command, then data
  task automatic rb(input logic [7:0] a, input logic [7:0] e);
    run(see_pkg::OP_READ, a);
    chk_rd("rd", DAT, {24'h0, e}, ALL);
  endtask
  // Main sequence
  initial
  begin
    logic [7:0] d;
    d = 8'($urandom(60));
    repeat (3) @(posedge clock_i);
    u_mem.mem[0] = SIG;
    for (int i = 1; i < 7; i++)
    begin
      st[i*8-8 +: 8] = 8'($urandom);
      u_mem.mem[i] = st[i*8-8 +: 8];
    end
    srst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    idle();
    chk_rd("cmd", CMD, 32'h100, 32'h8000_03FF);
    look("station", 2'h2, st);
    chk_rd("data", DAT, 32'h0, ALL);
    chk_rd("mask", MSK, 32'h0, ALL);
    wr(8'hC0, ALL);
    chk_rd("unmapped", 8'hC0, 32'h0, ALL);
    d = 8'($urandom % 32'hFF);
    wr(DAT, {24'hFF_FFFF, d});
    chk_rd("data", DAT, {24'h0, d}, ALL);
    run(see_pkg::OP_WRITE, 8'h10);
    rb(8'h10, ERASED);
    run(see_pkg::OP_EW_ENABLE, 8'h0);
    wr(DAT, {24'h0, d});
    run(see_pkg::OP_WRITE, 8'h10);
    rb(8'h10, d);
    run(see_pkg::OP_ERASE, 8'h10);
    rb(8'h10, ERASED);
    run(see_pkg::OP_BULK_ERASE, 8'h0);
    run(see_pkg::OP_RELOAD, 8'h0);
    chk_rd("cmd", CMD, 32'h0, 32'h300);
    rb(8'h0, ERASED);
    wr(DAT, {24'h0, SIG});
    run(see_pkg::OP_WRITE_ALL, 8'h0);
    rb(8'hFF, SIG);
    run(see_pkg::OP_RELOAD, 8'h0);
    chk_rd("cmd", CMD, 32'h100, 32'h300);
    look("station", 2'h2, {6{SIG}});
    run(see_pkg::OP_EW_DISABLE, 8'h0);
    wr(DAT, {24'h0, d});
    run(see_pkg::OP_WRITE, 8'h20);
    rb(8'h20, SIG);
    wr(CMD, {1'b1, see_pkg::OP_READ, 20'h0, 8'h05});
    chk_rd("busy", CMD, 32'h8000_0005, 32'h8000_00FF);
    wr(CMD, {1'b1, see_pkg::OP_WRITE, 20'h0, 8'h06});
    wr(DAT, 32'h11);
    idle();
    chk_rd("cmd", CMD, 32'h5, 32'hF000_00FF);
    chk_rd("data", DAT, {24'h0, SIG}, ALL);
    wr(STS, 32'h3);
    busy_ns <= 32'h1_3880;
    run(see_pkg::OP_EW_ENABLE, 8'h0);
    run(see_pkg::OP_WRITE, 8'h30);
    chk_rd("cmd", CMD, 32'h200, 32'h8000_0200);
    chk_rd("ists", STS, 32'h2, 32'h2);
    look("irq", 2'h1, 48'h0);
    wr(MSK, 32'h2);
    look("irq", 2'h1, 48'h1);
    wr(STS, 32'h2);
    look("irq", 2'h1, 48'h0);
    present <= 1'b0;
    for (int p = 0; p < 2; p++)
      for (int op = 3 * p; op < 7; op++)
      begin
        pull <= p[0];
        run(3'(op), 8'h40);
        chk_rd("timeout", CMD, {22'h0, p == 0 && op >= 3, 9'h0}, 32'h8000_0200);
      end
    wrap_up();
  end
endmodule
`default_nettype wire
